// file: hw/pac_pkg.sv
package pac_pkg;
  // Core clock and derived timing
  localparam int CLK_MHZ = 100;
  localparam int CLK_NS = 10;
  localparam int BUSY_MAX_NS = 45;
  localparam int BUSY_CYC = BUSY_MAX_NS / CLK_NS;
  localparam int CD2CU_NS = 40;
  localparam int CD2CU_CYC = (CD2CU_NS + CLK_NS - 1) / CLK_NS;
  localparam int TIMEOUT_US = 100;
  localparam int TIMEOUT_CYC_DEF = TIMEOUT_US * CLK_MHZ;
  localparam int INIT_OSC_MHZ = 10;
  localparam int OSC_DIV = CLK_MHZ / INIT_OSC_MHZ;
  localparam int USER_INIT_CYC = 299;
  localparam int INIT_OSC_CYC_DEF = 64;

  // Register map, byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_LEN = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_COUNT = 8'h0c;
  localparam int CTRL_AUTO_BIT = 0;
  localparam int CTRL_UCLK_BIT = 1;
  localparam int STAT_ERR_BIT = 8;
  localparam logic [1:0] CTRL_RST = 2'h1;
  localparam logic [15:0] LEN_RST = 16'h0010;

  // Stream layout
  localparam logic [7:0] SYNC_BYTE_DEF = 8'ha5;
  localparam logic [15:0] OPT_FRAME_IDX = 16'h0001;
  localparam int OPT_SF_BIT = 0;

  typedef enum logic [4:0] {
    ST_RESET = 5'h01,
    ST_LOAD = 5'h02,
    ST_INIT = 5'h04,
    ST_USER = 5'h08,
    ST_ERROR = 5'h10
  } pac_state_e;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
  } pac_phase_s;

  typedef struct packed {
    logic uclk;
    logic auto_rst;
  } pac_ctrl_s;
endpackage : pac_pkg

// file: hw/pac_config_port.sv
module pac_config_port import pac_pkg::*; #(
  parameter int unsigned TIMEOUT_CYC = TIMEOUT_CYC_DEF,
  parameter int unsigned INIT_OSC_CYC = INIT_OSC_CYC_DEF,
  parameter logic [7:0] SYNC_BYTE = SYNC_BYTE_DEF
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Configuration pins
  input wire logic config_restart_n,
  input wire logic select_low,
  input wire logic select_high,
  input wire logic write_strobe_n,
  input wire logic read_status_strobe_n,
  input wire logic [7:0] config_byte_bus,
  input wire logic chain_enable_in_n,
  input wire logic user_startup_clock,
  output logic ready_not_busy,
  output logic top_data_bit,
  output logic top_data_bit_oe,
  output logic chain_enable_out_n,
  // Open-drain lines
  input wire logic status_error_n_in,
  output logic status_error_n_o,
  output logic status_error_n_oe,
  input wire logic load_complete_in,
  output logic load_complete_o,
  output logic load_complete_oe,
  output logic startup_finished_o,
  output logic startup_finished_oe,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);
  pac_state_e st_r, st_nxt;
  pac_ctrl_s ctrl_r;
  pac_phase_s ph_r;
  logic [15:0] len_r, byte_cnt_r, init_cnt_r, err_cnt_r;
  logic [2:0] busy_cnt_r, dly_cnt_r;
  logic [3:0] div_cnt_r;
  logic ws_prev_r, uclk_prev_r, uclk_en_r;
  logic lc_rel_r, sf_en_r, err_sticky_r, od_low_r;
  logic ready_r, tdb_r, tdb_oe_r, chain_r, st_oe_r, lc_oe_r, sf_oe_r;
  logic hreadyout_r, hresp_r;
  logic [31:0] hrdata_r;

  // Pin-side decode
  wire sel_ok = !select_low && select_high && !chain_enable_in_n;
  wire ws_rise = !ws_prev_r && write_strobe_n;
  wire in_load = (st_r == ST_LOAD);
  wire cap = in_load && sel_ok && ws_rise;
  wire busy = (busy_cnt_r != 3'h0);
  wire sync_bad = (byte_cnt_r == 16'h0000) && (config_byte_bus != SYNC_BYTE);
  wire cfg_err = cap && (busy || sync_bad);
  wire cap_ok = cap && !cfg_err;
  wire [15:0] cnt_inc = byte_cnt_r + 16'h0001;
  wire last_cap = cap_ok && (cnt_inc == len_r);
  wire early_cap = cap_ok && (cnt_inc == len_r - 16'h0001);
  wire osc_tick = (div_cnt_r == 4'(OSC_DIV - 1));
  wire uclk_rise = !uclk_prev_r && user_startup_clock;
  wire peer_err = !status_error_n_in && !st_oe_r;
  wire init_done = ctrl_r.uclk ?
    (uclk_en_r && uclk_rise && init_cnt_r == 16'(USER_INIT_CYC - 1)) :
    (load_complete_in && osc_tick && init_cnt_r == 16'(INIT_OSC_CYC - 1));
  wire err_done = ctrl_r.auto_rst && (err_cnt_r == 16'(TIMEOUT_CYC - 1));

  always_comb begin
    st_nxt = st_r;
    if (!config_restart_n) begin
      st_nxt = ST_RESET;
    end else begin
      case (st_r)
        ST_RESET: st_nxt = ST_LOAD;
        ST_LOAD: begin
          if (cfg_err || peer_err) st_nxt = ST_ERROR;
          else if (last_cap) st_nxt = ST_INIT;
        end
        ST_INIT: begin
          if (peer_err) st_nxt = ST_ERROR;
          else if (init_done) st_nxt = ST_USER;
        end
        ST_USER: st_nxt = ST_USER;
        ST_ERROR: if (err_done) st_nxt = ST_LOAD;
        default: st_nxt = ST_RESET;
      endcase
    end
  end

  // Pin output next values
  wire nx_load = (st_nxt == ST_LOAD);
  wire nx_done = (st_nxt == ST_INIT) || (st_nxt == ST_USER);
  wire nx_active = nx_load && !chain_enable_in_n;
  wire lc_rel_nxt = nx_done || (nx_load && (lc_rel_r || early_cap || last_cap));
  wire sf_opt = cap_ok && byte_cnt_r == OPT_FRAME_IDX && config_byte_bus[OPT_SF_BIT];
  wire sf_en_nxt = (st_nxt != ST_RESET) && (st_nxt != ST_ERROR) && (sf_en_r || sf_opt);
  // The final byte still shows its busy window while the next device takes over
  wire nx_busy_ok = nx_load || (st_nxt == ST_INIT);
  wire ready_nxt = !(!chain_enable_in_n && nx_busy_ok && (cap || busy_cnt_r > 3'h1));

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= ST_RESET;
      ws_prev_r <= 1'b1;
      uclk_prev_r <= 1'b0;
      busy_cnt_r <= 3'h0;
      byte_cnt_r <= 16'h0000;
    end else begin
      st_r <= st_nxt;
      ws_prev_r <= write_strobe_n;
      uclk_prev_r <= user_startup_clock;
      busy_cnt_r <= cap ? 3'(BUSY_CYC) : (busy ? busy_cnt_r - 3'h1 : 3'h0);
      byte_cnt_r <= !nx_load ? 16'h0000 : (cap_ok ? cnt_inc : byte_cnt_r);
    end
  end

  // Initialization timing: tick divider, user-clock enable delay, cycle count
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      div_cnt_r <= 4'h0;
      dly_cnt_r <= 3'h0;
      uclk_en_r <= 1'b0;
      init_cnt_r <= 16'h0000;
    end else if (st_r != ST_INIT) begin
      div_cnt_r <= 4'h0;
      dly_cnt_r <= 3'h0;
      uclk_en_r <= 1'b0;
      init_cnt_r <= 16'h0000;
    end else begin
      div_cnt_r <= osc_tick ? 4'h0 : div_cnt_r + 4'h1;
      if (load_complete_in && !uclk_en_r) begin
        dly_cnt_r <= dly_cnt_r + 3'h1;
        uclk_en_r <= (dly_cnt_r == 3'(CD2CU_CYC - 1));
      end
      if (ctrl_r.uclk ? (uclk_en_r && uclk_rise) : (load_complete_in && osc_tick))
        init_cnt_r <= init_cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) err_cnt_r <= 16'h0000;
    else if (st_r != ST_ERROR) err_cnt_r <= 16'h0000;
    else if (!err_done) err_cnt_r <= err_cnt_r + 16'h0001;
  end

  // Pin flops; open-drain lines only ever pull low
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      od_low_r <= 1'b0;
      st_oe_r <= 1'b1;
      lc_oe_r <= 1'b1;
      lc_rel_r <= 1'b0;
      sf_en_r <= 1'b0;
      sf_oe_r <= 1'b0;
      ready_r <= 1'b1;
      tdb_r <= 1'b1;
      tdb_oe_r <= 1'b0;
      chain_r <= 1'b1;
    end else begin
      od_low_r <= 1'b0;
      st_oe_r <= (st_nxt == ST_RESET) || (st_nxt == ST_ERROR);
      lc_rel_r <= lc_rel_nxt;
      lc_oe_r <= !lc_rel_nxt;
      sf_en_r <= sf_en_nxt;
      sf_oe_r <= sf_en_nxt && (st_nxt != ST_USER);
      ready_r <= ready_nxt;
      tdb_r <= ready_nxt;
      tdb_oe_r <= nx_active && !read_status_strobe_n;
      chain_r <= !nx_done;
    end
  end

  // AHB-Lite slave, zero wait states, always OKAY
  wire ahb_take = hsel && htrans[1] && hready;
  wire ph_word = (ph_r.addr[1:0] == 2'h0);
  wire wr_ctrl = ph_r.wr && ph_word && ph_r.addr == REG_CTRL;
  wire wr_len = ph_r.wr && ph_word && ph_r.addr == REG_LEN;
  wire wr_stat = ph_r.wr && ph_word && ph_r.addr == REG_STAT;
  wire [31:0] stat_word = {22'h00_0000, lc_rel_r, err_sticky_r, 3'h0, st_r};
  wire [31:0] rd_mux =
    (haddr[7:0] == REG_CTRL) ? {30'h0000_0000, ctrl_r} :
    (haddr[7:0] == REG_LEN) ? {16'h0000, len_r} :
    (haddr[7:0] == REG_STAT) ? stat_word :
    (haddr[7:0] == REG_COUNT) ? {16'h0000, byte_cnt_r} : 32'h0000_0000;
  wire hi_zero = (haddr[31:8] == 24'h00_0000);
  wire err_clr = wr_stat && hwdata[STAT_ERR_BIT];

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ph_r <= '0;
      hrdata_r <= 32'h0000_0000;
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
    end else begin
      ph_r.wr <= ahb_take && hwrite && hsize == 3'h2 && hi_zero;
      ph_r.addr <= haddr[7:0];
      hrdata_r <= (ahb_take && !hwrite && hi_zero) ? rd_mux : 32'h0000_0000;
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_r <= CTRL_RST;
      len_r <= LEN_RST;
      err_sticky_r <= 1'b0;
    end else begin
      if (wr_ctrl) ctrl_r <= hwdata[1:0];
      if (wr_len) len_r <= hwdata[15:0];
      // A new error in the clearing cycle wins over the clear
      err_sticky_r <= cfg_err || (err_sticky_r && !err_clr);
    end
  end

  assign ready_not_busy = ready_r;
  assign top_data_bit = tdb_r;
  assign top_data_bit_oe = tdb_oe_r;
  assign chain_enable_out_n = chain_r;
  assign status_error_n_o = od_low_r;
  assign status_error_n_oe = st_oe_r;
  assign load_complete_o = od_low_r;
  assign load_complete_oe = lc_oe_r;
  assign startup_finished_o = od_low_r;
  assign startup_finished_oe = sf_oe_r;
  assign hreadyout = hreadyout_r;
  assign hresp = hresp_r;
  assign hrdata = hrdata_r;

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  restart_release_a: assert property ((st_r == ST_RESET && config_restart_n) |=> !status_error_n_oe)
    else $error("error line not released after restart");
  capture_busy_a: assert property (disable iff (sys_rst || !config_restart_n)
    (cap && !cfg_err && !chain_enable_in_n) |=> !ready_not_busy [*4] ##1 ready_not_busy)
    else $error("busy window wrong length");
  busy_bound_a: assert property (disable iff (sys_rst || !config_restart_n)
    $fell(ready_not_busy) |-> ##[1:4] ready_not_busy)
    else $error("busy longer than 45 ns");
  early_done_a: assert property (disable iff (sys_rst || !config_restart_n)
    early_cap |=> !load_complete_oe && st_r == ST_LOAD)
    else $error("load complete not released one byte early");
  error_pull_a: assert property (cfg_err && config_restart_n |=> status_error_n_oe && st_r == ST_ERROR)
    else $error("error not flagged");
  timeout_rel_a: assert property ((st_r == ST_ERROR && err_done && config_restart_n) |=> !status_error_n_oe)
    else $error("auto restart did not release");
  restart_pull_a: assert property (!config_restart_n |=> status_error_n_oe && load_complete_oe && !top_data_bit_oe)
    else $error("restart did not pull lines low");
  status_drive_a: assert property (top_data_bit_oe |-> $past(!read_status_strobe_n) && top_data_bit == ready_not_busy)
    else $error("top data bit driven wrongly");
  chain_pass_a: assert property (last_cap && config_restart_n |=> !chain_enable_out_n)
    else $error("chain enable out not driven");
  ignore_unsel_a: assert property ((ws_rise && !sel_ok) |-> !cap)
    else $error("unselected strobe captured");
  finish_rel_a: assert property ((st_r == ST_USER) |-> !startup_finished_oe && !load_complete_oe)
    else $error("lines not released in user mode");
  idle_ready_a: assert property ($past(chain_enable_in_n) |-> ready_not_busy)
    else $error("ready low while not selected");
  uclk_delay_a: assert property ($rose(uclk_en_r) |-> $past(load_complete_in, CD2CU_CYC))
    else $error("user clock enabled too soon");

  load_seen_c: cover property (last_cap);
  user_mode_c: cover property ($rose(st_r == ST_USER));
  auto_restart_c: cover property (st_r == ST_ERROR ##1 st_r == ST_LOAD);
  uclk_init_c: cover property (ctrl_r.uclk && init_done);
  restart_user_c: cover property (st_r == ST_USER && !config_restart_n);
endmodule : pac_config_port

// file: bench/pac_host_model.sv
module pac_host_model (
  // Clock and device status
  input wire logic clock,
  input wire logic ready_not_busy,
  // Host pins
  output logic write_strobe_n,
  output logic select_low,
  output logic select_high,
  output logic read_status_strobe_n,
  output logic [7:0] config_byte_bus
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    write_strobe_n = 1'b1;
    select_low = 1'b0;
    select_high = 1'b1;
    read_status_strobe_n = 1'b1;
    config_byte_bus = 8'h00;
  end

  task automatic send(input logic [7:0] b, input logic sel);
    int n;
    n = 0;
    @(posedge clock);
    while (ready_not_busy !== 1'b1 && n < 50) begin
      n++;
      @(posedge clock);
    end
    select_low <= ~sel;
    select_high <= sel;
    config_byte_bus <= b;
    write_strobe_n <= 1'b0;
    @(posedge clock);
    write_strobe_n <= 1'b1;
    @(posedge clock);
    // Data held one clock past the rise, then inverted so stale data must not pass for valid
    config_byte_bus <= ~b;
  endtask : send

  // Fixed pacing: worst busy time plus both strobe margins, ready is never looked at
  task automatic send_timed(input logic [7:0] b);
    repeat (9) @(posedge clock);
    config_byte_bus <= b;
    write_strobe_n <= 1'b0;
    @(posedge clock);
    write_strobe_n <= 1'b1;
    @(posedge clock);
    config_byte_bus <= ~b;
  endtask : send_timed

  task automatic status_pulse(input int n);
    read_status_strobe_n <= 1'b0;
    repeat (n) @(posedge clock);
    read_status_strobe_n <= 1'b1;
  endtask : status_pulse
endmodule : pac_host_model

// file: bench/parallel_async_config_port_test.sv
module parallel_async_config_port_test import pac_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TO_CYC = 20;
  localparam int OSC_TICKS = 4;
  localparam int UCLK_HALF = 3;
  localparam int RESTART_LOW_CYC = 200;

  logic clock, sys_rst, cfg_n, ce_n, uclk, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic wsn, sl, sh, rsn, rdy, tdb, tdb_oe, ceo_n, se_o, se_oe, lc_o, lc_oe, sf_o, sf_oe;
  logic [7:0] bus, b;
  int fails, checked, n, m;
  integer seed;
  logic [7:0] q[$];

  pac_config_port #(.TIMEOUT_CYC(TO_CYC), .INIT_OSC_CYC(OSC_TICKS)) dut_u (
    .clock(clock), .sys_rst(sys_rst), .config_restart_n(cfg_n), .select_low(sl), .select_high(sh),
    .write_strobe_n(wsn), .read_status_strobe_n(rsn), .config_byte_bus(bus), .chain_enable_in_n(ce_n),
    .user_startup_clock(uclk), .ready_not_busy(rdy), .top_data_bit(tdb), .top_data_bit_oe(tdb_oe),
    .chain_enable_out_n(ceo_n), .status_error_n_in(~se_oe), .status_error_n_o(se_o),
    .status_error_n_oe(se_oe), .load_complete_in(~lc_oe), .load_complete_o(lc_o),
    .load_complete_oe(lc_oe), .startup_finished_o(sf_o), .startup_finished_oe(sf_oe),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata)
  );

  pac_host_model host_u (
    .clock(clock), .ready_not_busy(rdy), .write_strobe_n(wsn), .select_low(sl), .select_high(sh),
    .read_status_strobe_n(rsn), .config_byte_bus(bus)
  );

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // User clock well under the core rate, kept toggling through restarts too
  always begin
    repeat (UCLK_HALF) @(posedge clock);
    uclk <= ~uclk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0000_00, a};
    hwrite <= wr;
    hsize <= 3'b010;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task automatic busy_cycles(output int c);
    c = 0;
    // Start in the cycle after capture, where ready has just gone low, so the first busy cycle is counted
    repeat (8) begin
      #1;
      if (rdy === 1'b0) c++;
      @(posedge clock);
    end
    #1;
  endtask : busy_cycles

  task automatic wait_for(ref logic s, input logic v, output int c);
    c = 0;
    while (s !== v && c < 2000) begin
      @(posedge clock);
      #1;
      c++;
    end
  endtask : wait_for

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report

  initial begin
    #100us;
    fails++;
    $display("watchdog expired");
    final_report();
  end

  initial begin
    {sys_rst, cfg_n, uclk, ce_n, hsel, hwrite, htrans, haddr, hwdata, hsize} = '0;
    sys_rst = 1'b1;
    cfg_n = 1'b1;
    seed = 32'h8b0f;
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    ahb(1'b0, REG_CTRL, '0, d);
    chk("ctrl reset", {30'h0, CTRL_RST}, d);
    chk("response", 32'h0, {31'h0, hresp});
    chk("pull level", 32'h0, {29'h0, se_o, lc_o, sf_o});
    ahb(1'b0, REG_LEN, '0, d);
    chk("len reset", {16'h0, LEN_RST}, d);
    ahb(1'b0, 8'h10, '0, d);
    chk("unmapped", 32'h0000_0000, d);
    ahb(1'b1, REG_LEN, 32'h0000_0004, d);
    ahb(1'b0, REG_LEN, '0, d);
    chk("len write", 32'h0000_0004, d);
    $display("test registers done");
    // Unselected strobes must leave the device idle and ready
    for (int k = 0; k < 2; k++) begin
      ce_n <= k[0];
      host_u.send(SYNC_BYTE_DEF, k[0]);
      busy_cycles(n);
      chk("ignored busy", 32'h0, n);
      host_u.status_pulse(3);
      #1;
      chk("status drive", {31'h0, ~k[0]}, tdb_oe);
      if (k == 0) chk("status bit", 32'h1, tdb);
    end
    ce_n <= 1'b0;
    ahb(1'b0, REG_COUNT, '0, d);
    chk("count ignored", 32'h0, d);
    $display("test select gating done");
    for (int i = 0; i < 4; i++) begin
      b = (i == 0) ? SYNC_BYTE_DEF : (i == 1) ? 8'h01 : 8'($random(seed));
      host_u.send(b, 1'b1);
      q.push_back(b);
      busy_cycles(n);
      chk("busy cycles", BUSY_CYC, n);
      chk("error line", 32'h0, se_oe);
      chk("done pull", {31'h0, i < 2}, lc_oe);
      chk("chain out", {31'h0, i != 3}, ceo_n);
      chk("startup pull", {31'h0, i >= 1}, sf_oe);
      ahb(1'b0, REG_COUNT, '0, d);
      // The count runs only while loading and clears once the stream is complete
      chk("count", (i < 3) ? 32'(q.size()) : 32'h0, d);
    end
    wait_for(sf_oe, 1'b0, n);
    chk("init time", 32'h1, {31'h0, n <= OSC_TICKS * OSC_DIV + 8});
    ahb(1'b0, REG_STAT, '0, d);
    chk("stat user", 32'h0000_0208, d);
    $display("test load done");
    cfg_n <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
    chk("restart error", 32'h1, se_oe);
    chk("restart done", 32'h1, lc_oe);
    // Hold the restart low for the full minimum pulse before letting go
    repeat (RESTART_LOW_CYC) @(posedge clock);
    cfg_n <= 1'b1;
    wait_for(se_oe, 1'b0, n);
    chk("release", 32'h0, se_oe);
    host_u.send(8'h3c, 1'b1);
    wait_for(se_oe, 1'b1, n);
    chk("bad sync", 32'h1, se_oe);
    wait_for(se_oe, 1'b0, m);
    chk("auto restart", 32'h1, {31'h0, m >= TO_CYC - 2 && m <= TO_CYC + 2});
    ahb(1'b0, REG_STAT, '0, d);
    chk("stat error", 32'h0000_0102, d);
    ahb(1'b1, REG_STAT, 32'h0000_0100, d);
    ahb(1'b0, REG_STAT, '0, d);
    chk("stat clear", 32'h0000_0002, d);
    $display("test error done");
    ahb(1'b1, REG_CTRL, 32'h0000_0003, d);
    ahb(1'b0, REG_CTRL, '0, d);
    chk("ctrl write", 32'h0000_0003, d);
    for (int i = 0; i < 4; i++) begin
      host_u.send_timed((i == 0) ? SYNC_BYTE_DEF : (i == 1) ? 8'h01 : 8'($random(seed)));
      #1;
      chk("timed error", 32'h0, se_oe);
    end
    wait_for(sf_oe, 1'b0, n);
    chk("user clock init", 32'h1, {31'h0, n >= 2 * UCLK_HALF * USER_INIT_CYC - 10 &&
      n <= 2 * UCLK_HALF * USER_INIT_CYC + CD2CU_CYC + 10});
    $display("test user clock done");
    final_report();
  end
endmodule : parallel_async_config_port_test
